// file: hdl/emrb_pkg.sv
package emrb_pkg;

  // Data width of the widest register
  localparam int unsigned DATA_W = 24;
  // Register address width
  localparam int unsigned ADDR_W = 8;

  // Measurement area addresses
  localparam logic [7:0] ADR_FAST_CURRENT_RMS     = 8'h00;
  localparam logic [7:0] ADR_CURRENT_WAVE_SAMPLE  = 8'h01;
  localparam logic [7:0] ADR_VOLTAGE_WAVE_SAMPLE  = 8'h03;
  localparam logic [7:0] ADR_CURRENT_RMS_VALUE    = 8'h04;
  localparam logic [7:0] ADR_VOLTAGE_RMS_VALUE    = 8'h06;
  localparam logic [7:0] ADR_ACTIVE_POWER_VALUE   = 8'h08;
  localparam logic [7:0] ADR_ENERGY_PULSE_COUNT   = 8'h0a;
  localparam logic [7:0] ADR_PHASE_ANGLE_VALUE    = 8'h0c;
  localparam logic [7:0] ADR_INTERNAL_TEMPERATURE = 8'h0e;
  localparam logic [7:0] ADR_EXTERNAL_TEMPERATURE = 8'h0f;

  // User area addresses
  localparam logic [7:0] ADR_FAST_RMS_CONTROL     = 8'h10;
  localparam logic [7:0] ADR_CURRENT_DC_OFFSET    = 8'h11;
  localparam logic [7:0] ADR_CURRENT_RMS_OFFSET   = 8'h13;
  localparam logic [7:0] ADR_POWER_OFFSET_TRIM    = 8'h15;
  localparam logic [7:0] ADR_NO_LOAD_THRESHOLD    = 8'h17;
  localparam logic [7:0] ADR_USER_MODE_SELECT     = 8'h18;
  localparam logic [7:0] ADR_KEYED_SOFT_RESET     = 8'h19;
  localparam logic [7:0] ADR_WRITE_UNLOCK_KEY     = 8'h1a;
  localparam logic [7:0] ADR_TEMPERATURE_CONTROL  = 8'h1b;
  localparam logic [7:0] ADR_EXT_TEMP_GAIN_TRIM   = 8'h1c;
  localparam logic [7:0] ADR_EXT_TEMP_OFFSET_TRIM = 8'h1d;

  // Values after reset
  localparam logic [23:0] RST_MEAS24           = 24'h00_0000;
  localparam logic [19:0] RST_WAVE             = 20'h0_0000;
  localparam logic [15:0] RST_PHASE            = 16'h0000;
  localparam logic [9:0]  RST_TEMP             = 10'h000;
  localparam logic [15:0] RST_FAST_RMS_CONTROL = 16'hffff;
  localparam logic [7:0]  RST_TRIM8            = 8'h00;
  localparam logic [7:0]  RST_NO_LOAD          = 8'h0b;
  localparam logic [15:0] RST_USER_MODE        = 16'h0000;
  localparam logic [23:0] RST_SOFT_RESET       = 24'h00_0000;
  localparam logic [7:0]  RST_UNLOCK           = 8'h00;
  localparam logic [15:0] RST_TEMP_CONTROL     = 16'h07ff;

  // Keys
  localparam logic [23:0] SOFT_RESET_KEY = 24'h5a_5a5a;
  localparam logic [7:0]  UNLOCK_KEY     = 8'h55;

  // Field position of the fast RMS half-cycle window select
  localparam int unsigned FAST_RMS_HALF_BIT = 15;

  // Zero-cross output delay
  localparam int unsigned CLK_PERIOD_NS = 50;
  localparam int unsigned ZX_DELAY_NS   = 571000;
  localparam int unsigned ZX_DELAY_CYC  = ZX_DELAY_NS / CLK_PERIOD_NS;

  // Zero-cross delay states
  typedef enum logic [1:0] {
    EMRB_ZX_IDLE = 2'b01,
    EMRB_ZX_WAIT = 2'b10
  } emrb_zx_state_t;

endpackage

// file: hdl/emrb_top.sv
`timescale 1ns/100ps
module emrb_top #(
  parameter int unsigned ZX_DELAY = emrb_pkg::ZX_DELAY_CYC
) (
  input  wire logic                        clock,
  input  wire logic                        rst_n,
  // Host register port, from the serial link engine
  input  wire logic                        host_wr,
  input  wire logic                        host_rd,
  input  wire logic [emrb_pkg::ADDR_W-1:0] host_addr,
  input  wire logic [emrb_pkg::DATA_W-1:0] host_wdata,
  output logic      [emrb_pkg::DATA_W-1:0] host_rdata,
  output logic                             host_rvalid,
  // Measurement update port, from the signal processing logic
  input  wire logic                        dsp_we,
  input  wire logic [emrb_pkg::ADDR_W-1:0] dsp_addr,
  input  wire logic [emrb_pkg::DATA_W-1:0] dsp_wdata,
  input  wire logic                        energy_pulse,
  input  wire logic                        voltage_sign,
  // Interface select pin and its decoded choice
  input  wire logic                        interface_select,
  output logic                             link_is_spi,
  // Settings driven to the signal processing logic
  output logic                             fast_rms_half_cycle,
  output logic      [15:0]                 fast_rms_control,
  output logic      [7:0]                  current_dc_offset_trim,
  output logic      [7:0]                  current_rms_offset_trim,
  output logic      [7:0]                  power_offset_trim,
  output logic      [7:0]                  no_load_threshold,
  output logic      [15:0]                 user_mode_select,
  output logic      [15:0]                 temperature_control,
  output logic      [7:0]                  ext_temp_gain_trim,
  output logic      [7:0]                  ext_temp_offset_trim,
  output logic                             user_writes_enabled,
  // Delayed zero-cross pin
  output logic                             zero_cross_output
);
  import emrb_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // Reset release

  logic [1:0] rst_sync_r;   // Two-stage release chain
  logic       rst_sync_n;   // Synchronised reset used everywhere

  // Assert at once, release after two edges
  // All parts leave reset on one edge
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rst_sync_r <= 2'b00;
    end else begin
      rst_sync_r <= {rst_sync_r[0], 1'b1};
    end
  end
  // Only the last stage leaves, so release is clean
  assign rst_sync_n = rst_sync_r[1];

  ////////////////////////////////////////////////////////////////////////
  // Interface select pin

  logic [2:0] sel_sync_r;   // Three-stage pin synchroniser
  logic       sel_r;        // Accepted select level

  // Sample the pin, accept once stages two and three agree
  // Reset level matches the idle pull-down
  always_ff @(posedge clock or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      sel_sync_r <= 3'b000;
      sel_r      <= 1'b0;
    end else begin
      sel_sync_r <= {sel_sync_r[1:0], interface_select};
      // A one-cycle spike never reaches sel_r
      if (sel_sync_r[1] == sel_sync_r[2]) begin
        sel_r <= sel_sync_r[2];
      end
    end
  end
  // Low picks the UART link, high SPI
  assign link_is_spi = sel_r;

  ////////////////////////////////////////////////////////////////////////
  // Write decode

  logic [7:0] unlock_r;   // Write unlock key
  logic       unlocked;   // Unlock register holds the key
  logic       user_area;  // Address lies in the user area
  logic       user_wr;    // Accepted user-area write
  logic       unlock_wr;  // Write to the unlock register itself
  logic       soft_rst;   // Keyed soft reset strike

  // Only the exact key opens the user area
  assign unlocked  = (unlock_r == UNLOCK_KEY);
  // From the first control register to the last trim
  assign user_area = (host_addr >= ADR_FAST_RMS_CONTROL) &&
                     (host_addr <= ADR_EXT_TEMP_OFFSET_TRIM);
  // Measurement addresses never reach a write strobe
  assign user_wr   = host_wr && user_area && unlocked;
  // The unlock register must stay writable to leave the locked state
  assign unlock_wr = host_wr && (host_addr == ADR_WRITE_UNLOCK_KEY);
  // The key acts only while open; other words are just kept
  assign soft_rst  = user_wr && (host_addr == ADR_KEYED_SOFT_RESET) &&
                     (host_wdata == SOFT_RESET_KEY);
  // Lock state for the processing logic
  assign user_writes_enabled = unlocked;

  ////////////////////////////////////////////////////////////////////////
  // User area registers

  // Registers of the user area
  logic [15:0] fast_ctrl_r;    // Fast RMS control
  logic [7:0]  dc_os_r;        // Current DC offset trim
  logic [7:0]  rms_os_r;       // Current RMS offset trim
  logic [7:0]  pwr_os_r;       // Active power offset trim
  logic [7:0]  no_load_r;      // No-load threshold
  logic [15:0] mode_r;         // User mode select
  logic [23:0] soft_r;         // Last soft reset word
  logic [15:0] tctrl_r;        // Temperature control
  logic [7:0]  tgain_r;        // External sensor gain trim
  logic [7:0]  toffs_r;        // External sensor offset trim

  // Hold, load on an accepted write, or restore defaults
  always_ff @(posedge clock or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      fast_ctrl_r <= RST_FAST_RMS_CONTROL;
      dc_os_r     <= RST_TRIM8;
      rms_os_r    <= RST_TRIM8;
      pwr_os_r    <= RST_TRIM8;
      no_load_r   <= RST_NO_LOAD;
      mode_r      <= RST_USER_MODE;
      soft_r      <= RST_SOFT_RESET;
      // Power-up leaves the user area locked
      unlock_r    <= RST_UNLOCK;
      tctrl_r     <= RST_TEMP_CONTROL;
      tgain_r     <= RST_TRIM8;
      toffs_r     <= RST_TRIM8;
    end else if (soft_rst) begin
      // Keyed restore of the whole user area
      // Unlock is restored too, so the area locks
      fast_ctrl_r <= RST_FAST_RMS_CONTROL;
      dc_os_r     <= RST_TRIM8;
      rms_os_r    <= RST_TRIM8;
      pwr_os_r    <= RST_TRIM8;
      no_load_r   <= RST_NO_LOAD;
      mode_r      <= RST_USER_MODE;
      soft_r      <= RST_SOFT_RESET;
      unlock_r    <= RST_UNLOCK;
      tctrl_r     <= RST_TEMP_CONTROL;
      tgain_r     <= RST_TRIM8;
      toffs_r     <= RST_TRIM8;
    end else begin
      // Unlock register: any value stored, only the key opens
      if (unlock_wr) begin
        unlock_r <= host_wdata[7:0];
      end
      // One register per accepted write
      if (user_wr) begin
        case (host_addr)
          ADR_FAST_RMS_CONTROL:     fast_ctrl_r <= host_wdata[15:0];
          ADR_CURRENT_DC_OFFSET:    dc_os_r     <= host_wdata[7:0];
          ADR_CURRENT_RMS_OFFSET:   rms_os_r    <= host_wdata[7:0];
          ADR_POWER_OFFSET_TRIM:    pwr_os_r    <= host_wdata[7:0];
          ADR_NO_LOAD_THRESHOLD:    no_load_r   <= host_wdata[7:0];
          ADR_USER_MODE_SELECT:     mode_r      <= host_wdata[15:0];
          ADR_KEYED_SOFT_RESET:     soft_r      <= host_wdata;
          ADR_TEMPERATURE_CONTROL:  tctrl_r     <= host_wdata[15:0];
          ADR_EXT_TEMP_GAIN_TRIM:   tgain_r     <= host_wdata[7:0];
          ADR_EXT_TEMP_OFFSET_TRIM: toffs_r     <= host_wdata[7:0];
          // Holes at 0x12, 0x14 and 0x16 keep nothing
          default: ;  // Holes and the unlock register
        endcase
      end
    end
  end

  // Settings out to the processing logic
  // Straight from the registers, no added delay
  assign fast_rms_control        = fast_ctrl_r;
  // Set picks the half-cycle window
  assign fast_rms_half_cycle     = fast_ctrl_r[FAST_RMS_HALF_BIT];
  assign current_dc_offset_trim  = dc_os_r;
  assign current_rms_offset_trim = rms_os_r;
  assign power_offset_trim       = pwr_os_r;
  assign no_load_threshold       = no_load_r;
  assign user_mode_select        = mode_r;
  assign temperature_control     = tctrl_r;
  assign ext_temp_gain_trim      = tgain_r;
  assign ext_temp_offset_trim    = toffs_r;

  ////////////////////////////////////////////////////////////////////////
  // Measurement registers, written only by the processing logic

  // Processing results, zero after reset
  logic [23:0] frms_r;     // Fast current RMS
  logic [19:0] iwave_r;    // Current wave sample
  logic [19:0] vwave_r;    // Voltage wave sample
  logic [23:0] irms_r;     // Current RMS
  logic [23:0] vrms_r;     // Voltage RMS
  logic [23:0] power_r;    // Active power, signed
  logic [23:0] pcount_r;   // Energy pulse count
  logic [15:0] phase_r;    // Phase angle
  logic [9:0]  tint_r;     // Internal temperature
  logic [9:0]  text_r;     // External temperature
  logic        cnt_load;   // Processing logic loads the count

  // The count has its own process below
  assign cnt_load = dsp_we && (dsp_addr == ADR_ENERGY_PULSE_COUNT);

  // Load from the processing port only
  // One register per load cycle
  always_ff @(posedge clock or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      frms_r  <= RST_MEAS24;
      iwave_r <= RST_WAVE;
      vwave_r <= RST_WAVE;
      irms_r  <= RST_MEAS24;
      vrms_r  <= RST_MEAS24;
      power_r <= RST_MEAS24;
      phase_r <= RST_PHASE;
      tint_r  <= RST_TEMP;
      text_r  <= RST_TEMP;
    end else if (dsp_we) begin
      // Narrow registers keep the low bits
      case (dsp_addr)
        ADR_FAST_CURRENT_RMS:     frms_r  <= dsp_wdata;
        ADR_CURRENT_WAVE_SAMPLE:  iwave_r <= dsp_wdata[19:0];
        ADR_VOLTAGE_WAVE_SAMPLE:  vwave_r <= dsp_wdata[19:0];
        ADR_CURRENT_RMS_VALUE:    irms_r  <= dsp_wdata;
        ADR_VOLTAGE_RMS_VALUE:    vrms_r  <= dsp_wdata;
        ADR_ACTIVE_POWER_VALUE:   power_r <= dsp_wdata;
        ADR_PHASE_ANGLE_VALUE:    phase_r <= dsp_wdata[15:0];
        ADR_INTERNAL_TEMPERATURE: tint_r  <= dsp_wdata[9:0];
        ADR_EXTERNAL_TEMPERATURE: text_r  <= dsp_wdata[9:0];
        default: ;  // Count handled below, user area not reachable
      endcase
    end
  end

  // Energy pulse counter, load wins over a coincident pulse
  // Host writes never reach the count
  always_ff @(posedge clock or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      pcount_r <= RST_MEAS24;
    end else if (cnt_load) begin
      pcount_r <= dsp_wdata;
    end else if (energy_pulse) begin
      // Rolls over to zero past the top
      pcount_r <= pcount_r + 24'h00_0001;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Read path, open regardless of the lock

  logic [23:0] rd_mux;   // Selected read word

  // Narrow values sit low; signed samples extend their sign
  // Unmapped addresses read as zero
  // Reads ignore the lock, state stays visible
  assign rd_mux =
    (host_addr == ADR_FAST_CURRENT_RMS)     ? frms_r :
    (host_addr == ADR_CURRENT_WAVE_SAMPLE)  ? {{4{iwave_r[19]}}, iwave_r} :
    (host_addr == ADR_VOLTAGE_WAVE_SAMPLE)  ? {{4{vwave_r[19]}}, vwave_r} :
    (host_addr == ADR_CURRENT_RMS_VALUE)    ? irms_r :
    (host_addr == ADR_VOLTAGE_RMS_VALUE)    ? vrms_r :
    (host_addr == ADR_ACTIVE_POWER_VALUE)   ? power_r :
    (host_addr == ADR_ENERGY_PULSE_COUNT)   ? pcount_r :
    (host_addr == ADR_PHASE_ANGLE_VALUE)    ? {8'h00, phase_r} :
    (host_addr == ADR_INTERNAL_TEMPERATURE) ? {14'h0000, tint_r} :
    (host_addr == ADR_EXTERNAL_TEMPERATURE) ? {14'h0000, text_r} :
    (host_addr == ADR_FAST_RMS_CONTROL)     ? {8'h00, fast_ctrl_r} :
    (host_addr == ADR_CURRENT_DC_OFFSET)    ? {16'h0000, dc_os_r} :
    (host_addr == ADR_CURRENT_RMS_OFFSET)   ? {16'h0000, rms_os_r} :
    (host_addr == ADR_POWER_OFFSET_TRIM)    ? {16'h0000, pwr_os_r} :
    (host_addr == ADR_NO_LOAD_THRESHOLD)    ? {16'h0000, no_load_r} :
    (host_addr == ADR_USER_MODE_SELECT)     ? {8'h00, mode_r} :
    (host_addr == ADR_KEYED_SOFT_RESET)     ? soft_r :
    (host_addr == ADR_WRITE_UNLOCK_KEY)     ? {16'h0000, unlock_r} :
    (host_addr == ADR_TEMPERATURE_CONTROL)  ? {8'h00, tctrl_r} :
    (host_addr == ADR_EXT_TEMP_GAIN_TRIM)   ? {16'h0000, tgain_r} :
    (host_addr == ADR_EXT_TEMP_OFFSET_TRIM) ? {16'h0000, toffs_r} :
    24'h00_0000;

  // Register the answer one edge after the request
  // The answer flag lasts one cycle
  always_ff @(posedge clock or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      host_rdata  <= 24'h00_0000;
      host_rvalid <= 1'b0;
    end else begin
      host_rvalid <= host_rd;
      // Data holds between reads
      if (host_rd) begin
        host_rdata <= rd_mux;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Zero-cross output delay

  // Fourteen bits cover the default delay
  // Longer delays need a wider counter
  localparam logic [13:0] ZX_LAST = 14'(ZX_DELAY - 1);

  emrb_zx_state_t zx_state_r;   // Delay state
  logic           sign_r;       // Previous voltage sign
  logic           zx_target_r;  // Level to show at expiry
  logic [13:0]    zx_cnt_r;     // Delay counter
  logic           zx_edge;      // Sign changed this cycle
  logic           zx_done;      // Delay has run out

  // Sign change against last cycle
  assign zx_edge = (voltage_sign != sign_r);
  assign zx_done = (zx_cnt_r == ZX_LAST);

  // Start on a crossing, show the new level once the delay ends
  // Output moves ZX_DELAY cycles after the change is seen
  always_ff @(posedge clock or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      zx_state_r        <= EMRB_ZX_IDLE;
      sign_r            <= 1'b0;
      zx_target_r       <= 1'b0;
      zx_cnt_r          <= 14'h0000;
      zero_cross_output <= 1'b0;
    end else begin
      // Keep last sign for edge detection
      sign_r <= voltage_sign;
      case (zx_state_r)
        EMRB_ZX_IDLE: begin
          if (zx_edge) begin
            // Latch the new level, start counting
            zx_target_r <= voltage_sign;
            zx_cnt_r    <= 14'h0000;
            zx_state_r  <= EMRB_ZX_WAIT;
          end
        end
        EMRB_ZX_WAIT: begin
          // Sign changes here are dropped; sign_r keeps tracking, so idle sees no edge
          if (zx_done) begin
            zero_cross_output <= zx_target_r;
            zx_state_r        <= EMRB_ZX_IDLE;
          end else begin
            zx_cnt_r <= zx_cnt_r + 14'h0001;
          end
        end
        default: begin
          // Illegal code: back to idle
          zx_state_r <= EMRB_ZX_IDLE;
        end
      endcase
    end
  end

endmodule

// file: sim/emrb_assertions.sv
`timescale 1ns/100ps
////////////////////////////////////////////////////////////////////////////
// Port-level checker of the register bank
module emrb_checker
  import emrb_pkg::*;
#(
  parameter int unsigned ZX_DELAY = ZX_DELAY_CYC
) (
  input wire logic                        clock,
  input wire logic                        rst_n,
  input wire logic                        host_wr,
  input wire logic                        host_rd,
  input wire logic [emrb_pkg::ADDR_W-1:0] host_addr,
  input wire logic [emrb_pkg::DATA_W-1:0] host_wdata,
  input wire logic                        host_rvalid,
  input wire logic                        voltage_sign,
  input wire logic                        fast_rms_half_cycle,
  input wire logic [15:0]                 fast_rms_control,
  input wire logic [7:0]                  no_load_threshold,
  input wire logic [15:0]                 temperature_control,
  input wire logic                        user_writes_enabled,
  input wire logic                        zero_cross_output
);
  // One clock domain, one reset
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  // Locked or unlocked write to the threshold register
  wire wr_thr = host_wr && host_addr == ADR_NO_LOAD_THRESHOLD;

  AST_RD_ANSWER: assert property (host_rd |=> host_rvalid)
    else $error("read not answered next cycle");
  AST_RD_QUIET: assert property (!host_rd |=> !host_rvalid)
    else $error("read answer without a read");
  AST_LOCKED: assert property (!user_writes_enabled && wr_thr
    |=> $stable(no_load_threshold)) else $error("locked write landed");
  AST_UNLOCK: assert property (host_wr
    && host_addr == ADR_WRITE_UNLOCK_KEY && host_wdata[7:0] == UNLOCK_KEY
    |=> user_writes_enabled)
    else $error("unlock key did not enable writes");
  AST_WRITE: assert property (user_writes_enabled && wr_thr
    |=> no_load_threshold == $past(host_wdata[7:0]))
    else $error("unlocked write lost");
  AST_SOFT_RST: assert property (user_writes_enabled && host_wr
    && host_addr == ADR_KEYED_SOFT_RESET && host_wdata == SOFT_RESET_KEY
    |=> fast_rms_control == 16'hffff && no_load_threshold == 8'h0b
    && temperature_control == 16'h07ff && !user_writes_enabled)
    else $error("soft reset left user values");
  AST_HALF: assert property (
    fast_rms_half_cycle == fast_rms_control[15])
    else $error("window select not bit 15");
  AST_ZX: assert property ($changed(zero_cross_output)
    |-> zero_cross_output == $past(voltage_sign, ZX_DELAY + 1))
    else $error("zero cross moved at wrong time");
endmodule

bind emrb_top emrb_checker #(.ZX_DELAY(ZX_DELAY)) u_chk (
  .clock(clock), .rst_n(rst_n), .host_wr(host_wr), .host_rd(host_rd),
  .host_addr(host_addr), .host_wdata(host_wdata),
  .host_rvalid(host_rvalid), .voltage_sign(voltage_sign),
  .fast_rms_half_cycle(fast_rms_half_cycle),
  .fast_rms_control(fast_rms_control),
  .no_load_threshold(no_load_threshold),
  .temperature_control(temperature_control),
  .user_writes_enabled(user_writes_enabled),
  .zero_cross_output(zero_cross_output));

// file: sim/emrb_host_model.sv
`timescale 1ns/100ps
////////////////////////////////////////////////////////////////////////////
// Host side of the register port
module emrb_host_model
  import emrb_pkg::*;
(
  input  wire logic                        clock,
  output logic                             host_wr,
  output logic                             host_rd,
  output logic      [emrb_pkg::ADDR_W-1:0] host_addr,
  output logic      [emrb_pkg::DATA_W-1:0] host_wdata,
  input  wire logic [emrb_pkg::DATA_W-1:0] host_rdata,
  input  wire logic                        host_rvalid
);
  // Idle port at time zero
  initial begin
    host_wr    = 1'b0;
    host_rd    = 1'b0;
    host_addr  = 8'h00;
    host_wdata = 24'h00_0000;
  end

  // One-cycle write; released lines show the inverse
  task automatic wr(input logic [7:0] a, input logic [23:0] d);
    @(posedge clock);
    host_wr    <= 1'b1;
    host_addr  <= a;
    host_wdata <= d;
    @(posedge clock);
    host_wr    <= 1'b0;
    host_addr  <= ~a;
    host_wdata <= ~d;
  endtask

  // One-cycle read; answer taken at the edge after the read edge
  task automatic rd(input logic [7:0] a, output logic [23:0] d,
                    output logic v);
    @(posedge clock);
    host_rd   <= 1'b1;
    host_addr <= a;
    @(posedge clock);
    host_rd   <= 1'b0;
    host_addr <= ~a;
    @(posedge clock);
    d = host_rdata;
    v = host_rvalid;
  endtask
endmodule

// file: sim/emrb_top_tb.sv
`timescale 1ns/100ps
////////////////////////////////////////////////////////////////////////////
// Self-checking bench of the register bank
module emrb_top_tb;
  import emrb_pkg::*;
  localparam int unsigned ZXD = 8;  // Short zero-cross delay
  logic        clock = 1'b0;       // 20 MHz clock
  logic        rst_n = 1'b0;       // Reset, active low
  logic        host_wr;
  logic        host_rd;
  logic [7:0]  host_addr;
  logic [23:0] host_wdata;
  logic [23:0] host_rdata;
  logic        host_rvalid;
  logic        dsp_we = 1'b0;      // Measurement load strobe
  logic [7:0]  dsp_addr = 8'h00;
  logic [23:0] dsp_wdata = 24'h00_0000;
  logic        energy_pulse = 1'b0;
  logic        voltage_sign = 1'b0;
  logic        sel_pin = 1'b0;     // Interface select pin
  logic        link_is_spi;
  logic        user_writes_enabled;
  logic        zx;
  logic        half;
  logic [7:0]  ptrim;
  int          error_cnt = 0;
  int          num_checks = 0;
  int          cyc = 0;
  int          n;
  logic [7:0]  ra [7] = '{8'h10, 8'h11, 8'h13, 8'h15, 8'h17, 8'h1b, 8'h1e};
  logic [23:0] rv [7] = '{24'h00_ffff, 24'h0, 24'h0, 24'h0, 24'h00_000b,
                          24'h00_07ff, 24'h0};

  always #25 clock = ~clock;

  emrb_host_model host (.clock(clock), .host_wr(host_wr),
    .host_rd(host_rd), .host_addr(host_addr), .host_wdata(host_wdata),
    .host_rdata(host_rdata), .host_rvalid(host_rvalid));

  emrb_top #(.ZX_DELAY(ZXD)) DUT (.clock(clock), .rst_n(rst_n),
    .host_wr(host_wr), .host_rd(host_rd), .host_addr(host_addr),
    .host_wdata(host_wdata), .host_rdata(host_rdata),
    .host_rvalid(host_rvalid), .dsp_we(dsp_we), .dsp_addr(dsp_addr),
    .dsp_wdata(dsp_wdata), .energy_pulse(energy_pulse),
    .voltage_sign(voltage_sign), .interface_select(sel_pin),
    .link_is_spi(link_is_spi), .fast_rms_half_cycle(half),
    .fast_rms_control(), .current_dc_offset_trim(),
    .current_rms_offset_trim(), .power_offset_trim(ptrim),
    .no_load_threshold(), .user_mode_select(), .temperature_control(),
    .ext_temp_gain_trim(), .ext_temp_offset_trim(),
    .user_writes_enabled(user_writes_enabled), .zero_cross_output(zx));

  // Compare and count
  task automatic check(input logic [23:0] seen, input logic [23:0] exp);
    num_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t seen %h exp %h", $time, seen, exp);
    end
  endtask

  // Read one register, expect answer flag and value
  task automatic rchk(input logic [7:0] a, input logic [23:0] e);
    logic [23:0] d;
    logic        v;
    host.rd(a, d, v);
    check({23'h0, v}, 24'h1);
    check(d, e);
  endtask

  // Measurement load from the processing side
  task automatic dsp(input logic [7:0] a, input logic [23:0] d);
    @(posedge clock);
    dsp_we    <= 1'b1;
    dsp_addr  <= a;
    dsp_wdata <= d;
    @(posedge clock);
    dsp_we    <= 1'b0;
  endtask

  // Verdict and end of run
  task automatic finish_test();
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // Hang guard
  always @(posedge clock) begin
    cyc++;
    if (cyc == 5000) begin
      error_cnt++;
      finish_test();
    end
  end

  initial begin
    repeat (2) @(posedge clock);
    rst_n <= 1'b1;
    repeat (3) @(posedge clock);
    // Reset values and an unmapped place
    for (int i = 0; i < 7; i++) rchk(ra[i], rv[i]);
    rchk(ADR_CURRENT_RMS_VALUE, 24'h0);
    check({23'h0, half}, 24'h1);
    $display("test reset values done");
    // Locked writes ignored, then unlock
    host.wr(ADR_NO_LOAD_THRESHOLD, 24'h00_0022);
    rchk(ADR_NO_LOAD_THRESHOLD, 24'h00_000b);
    host.wr(ADR_WRITE_UNLOCK_KEY, 24'h00_0054);
    host.wr(ADR_CURRENT_DC_OFFSET, 24'h00_0011);
    rchk(ADR_CURRENT_DC_OFFSET, 24'h0);
    host.wr(ADR_WRITE_UNLOCK_KEY, 24'h00_0055);
    host.wr(ADR_NO_LOAD_THRESHOLD, 24'h00_0022);
    host.wr(ADR_TEMPERATURE_CONTROL, 24'h00_1234);
    host.wr(ADR_POWER_OFFSET_TRIM, 24'hff_ffa5);
    host.wr(ADR_FAST_RMS_CONTROL, 24'h00_7abc);
    host.wr(ADR_FAST_CURRENT_RMS, 24'h12_3456);
    host.wr(ADR_USER_MODE_SELECT, 24'h00_1203);
    host.wr(ADR_CURRENT_RMS_OFFSET, 24'h00_005a);
    host.wr(ADR_EXT_TEMP_GAIN_TRIM, 24'h00_003c);
    host.wr(ADR_EXT_TEMP_OFFSET_TRIM, 24'h00_00c3);
    rchk(ADR_NO_LOAD_THRESHOLD, 24'h00_0022);
    rchk(ADR_TEMPERATURE_CONTROL, 24'h00_1234);
    rchk(ADR_POWER_OFFSET_TRIM, 24'h00_00a5);
    rchk(ADR_FAST_RMS_CONTROL, 24'h00_7abc);
    rchk(ADR_FAST_CURRENT_RMS, 24'h0);
    rchk(ADR_USER_MODE_SELECT, 24'h00_1203);
    rchk(ADR_CURRENT_RMS_OFFSET, 24'h00_005a);
    rchk(ADR_EXT_TEMP_GAIN_TRIM, 24'h00_003c);
    rchk(ADR_EXT_TEMP_OFFSET_TRIM, 24'h00_00c3);
    check({23'h0, half}, 24'h0);
    check({16'h0, ptrim}, 24'h00_00a5);
    $display("test write protect done");
    // Measurement loads, signed widths and pulse count
    dsp(ADR_CURRENT_WAVE_SAMPLE, 24'h08_0001);
    dsp(ADR_ACTIVE_POWER_VALUE, 24'h80_0000);
    dsp(ADR_INTERNAL_TEMPERATURE, 24'hff_ffff);
    dsp(ADR_PHASE_ANGLE_VALUE, 24'hab_cdef);
    dsp(ADR_NO_LOAD_THRESHOLD, 24'h00_0077);
    repeat (3) begin
      @(posedge clock);
      energy_pulse <= 1'b1;
      @(posedge clock);
      energy_pulse <= 1'b0;
    end
    rchk(ADR_CURRENT_WAVE_SAMPLE, 24'hf8_0001);
    rchk(ADR_ACTIVE_POWER_VALUE, 24'h80_0000);
    rchk(ADR_INTERNAL_TEMPERATURE, 24'h00_03ff);
    rchk(ADR_PHASE_ANGLE_VALUE, 24'h00_cdef);
    rchk(ADR_ENERGY_PULSE_COUNT, 24'h00_0003);
    dsp(ADR_ENERGY_PULSE_COUNT, 24'h00_0100);
    rchk(ADR_ENERGY_PULSE_COUNT, 24'h00_0100);
    rchk(ADR_NO_LOAD_THRESHOLD, 24'h00_0022);
    $display("test measurements done");
    // Keyed soft reset restores defaults and relocks
    host.wr(ADR_KEYED_SOFT_RESET, SOFT_RESET_KEY);
    rchk(ADR_NO_LOAD_THRESHOLD, 24'h00_000b);
    rchk(ADR_WRITE_UNLOCK_KEY, 24'h0);
    rchk(ADR_USER_MODE_SELECT, 24'h0);
    check({16'h0, ptrim}, 24'h0);
    check({23'h0, user_writes_enabled}, 24'h0);
    $display("test soft reset done");
    // Zero-cross delay, counted from the edge that drives the sign
    @(posedge clock);
    voltage_sign <= 1'b1;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (zx !== 1'b1 && n < 100);
    // Output moves ZXD + 1 edges on, seen at the edge after
    check(24'(n), 24'(ZXD + 2));
    $display("test zero cross done");
    // Interface select follows the pin
    sel_pin <= 1'b1;
    repeat (8) @(posedge clock);
    check({23'h0, link_is_spi}, 24'h1);
    sel_pin <= 1'b0;
    repeat (8) @(posedge clock);
    check({23'h0, link_is_spi}, 24'h0);
    $display("test select done");
    finish_test();
  end
endmodule
